// *** design/host_port_regs.vh ***
// register map, field positions, reset values and codes of the host byte port
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// software register byte offsets
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_MASK_OFS 8'h08
`define REG_POINTER_OFS 8'h0C
`define REG_TXCTRL_OFS 8'h10

// control register fields
`define CTRL_AUTO_INC_BIT 0
`define CTRL_RESET 32'h0000_0000

// interrupt cause bits, shared by status and mask
`define IRQ_WIDTH 4
`define IRQ_HOST_WRITE_BIT 0
`define IRQ_HOST_READ_BIT 1
`define IRQ_TX_READY_BIT 2
`define IRQ_RX_READY_BIT 3
`define STATUS_RESET 4'h0
`define MASK_RESET 4'h0

`define POINTER_RESET 16'h0000
`define TXCTRL_RESET 8'h00

// host register codes on the two select lines
`define HREG_ADDR_LO 2'h0
`define HREG_ADDR_HI 2'h1
`define HREG_DATA_INCR 2'h2
`define HREG_DATA_PLAIN 2'h3

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** design/sync_stage.v ***
// two flip-flop synchroniser for a group of level inputs
`default_nettype none

module sync_stage #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire nrst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  // first stage feeds only the second
  reg [WIDTH-1:0] meta_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** design/axil_slave.v ***
// axi4-lite slave handshake; register decode stays with the caller
`include "host_port_regs.vh"
`default_nettype none

module axil_slave (
  input wire clk,
  input wire nrst,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg wrEn,
  output reg [7:0] wrAddr,
  output reg [31:0] wrData,
  output reg [3:0] wrStrb,
  input wire wrErr,
  output reg [7:0] rdAddr,
  input wire [31:0] rdData,
  input wire rdErr
);

  reg awTaken_r;
  reg wTaken_r;
  reg rdPend_r;

  wire awFire = awvalid && awready;
  wire wFire = wvalid && wready;
  wire awHave = awTaken_r || awFire;
  wire wHave = wTaken_r || wFire;

  ////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awTaken_r <= 1'b0;
      wTaken_r <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      wrEn <= 1'b0;
      wrAddr <= 8'h00;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else begin
      wrEn <= 1'b0;
      if (awFire) begin
        wrAddr <= awaddr;
        awready <= 1'b0;
      end
      if (wFire) begin
        wrData <= wdata;
        wrStrb <= wstrb;
        wready <= 1'b0;
      end
      awTaken_r <= awHave;
      wTaken_r <= wHave;
      // one write in flight: both halves present, then apply
      if (awTaken_r && wTaken_r && !bvalid && !wrEn) begin
        wrEn <= 1'b1;
      end
      if (wrEn) begin
        bvalid <= 1'b1;
        bresp <= wrErr ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awTaken_r <= 1'b0;
        wTaken_r <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rdPend_r <= 1'b0;
      rdAddr <= 8'h00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      rdPend_r <= 1'b0;
      if (arvalid && arready) begin
        rdAddr <= araddr;
        arready <= 1'b0;
        rdPend_r <= 1'b1;
      end
      if (rdPend_r) begin
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdErr ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// *** design/host_byte_port.v ***
// byte-wide host access port with indirect pointer, management ready flags and interrupt
//
// The AXI4-Lite register port and the address map were decided locally.
`include "host_port_regs.vh"
`default_nettype none

module host_byte_port #(
  parameter ADDR_W = 16,
  parameter FLAGS = 8
) (
  input wire clk,
  input wire nrst,
  input wire portSelectN,
  input wire readNotWrite,
  input wire hostRegSelectHi,
  input wire hostRegSelectLo,
  input wire dmaModeN,
  input wire [7:0] hostByteIn,
  output reg [7:0] hostByteOut,
  output reg hostByteOeN,
  output reg hostReadyNOut,
  output reg hostReadyOeN,
  output reg hostIrq,
  output reg mgmtRxReady,
  output reg mgmtTxReady,
  input wire rxBufEmpty,
  input wire [FLAGS-1:0] eofFlags,
  input wire [FLAGS-1:0] sofFlags,
  output reg intReq,
  output reg intWe,
  output reg [1:0] intSel,
  output reg [ADDR_W-1:0] intAddr,
  output reg [7:0] intWdata,
  input wire [7:0] intRdata,
  input wire intAck,
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WRWAIT = 3'h1;
  localparam [2:0] ST_ACCESS = 3'h2;
  localparam [2:0] ST_RDHOLD = 3'h3;
  localparam [2:0] ST_RDYLO = 3'h4;
  localparam [2:0] ST_RDYHI = 3'h5;

  wire rstN;
  wire [12:0] pinSync;
  // select is stored inverted so that the synchroniser's reset value reads as idle
  wire selNS = !pinSync[12];
  wire rnwS = pinSync[11];
  wire selHiS = pinSync[10];
  wire selLoS = pinSync[9];
  wire dmaNS = pinSync[8];
  wire [7:0] byteS = pinSync[7:0];

  reg [2:0] state_r, state_nxt;
  reg isRead_r, isRead_nxt;
  reg [1:0] reg_r, reg_nxt;
  reg [7:0] wrByte_r, wrByte_nxt;
  reg [ADDR_W-1:0] pointer_r, pointer_nxt;
  reg [7:0] byteOut_nxt;
  reg byteOeN_nxt, readyN_nxt, readyOeN_nxt, intReq_nxt;
  reg doneWrite, doneRead;
  reg autoInc_r;
  reg [7:0] txCtrl_r;
  reg [`IRQ_WIDTH-1:0] status_r, mask_r;
  reg txReadyLast_r, rxReadyLast_r;
  reg [1:0] dmaSel;
  reg [`IRQ_WIDTH-1:0] irqSet;
  reg [31:0] regRd;
  reg regRdErr;

  wire wrEn;
  wire [7:0] wrAddr, rdAddr;
  wire [31:0] wrData;
  wire [3:0] wrStrb;
  wire isLocal = (reg_r == `HREG_ADDR_LO) || (reg_r == `HREG_ADDR_HI);
  wire [ADDR_W-1:0] pointerInc = pointer_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [15:0] pointerWide = {{(16-ADDR_W){1'b0}}, pointer_r};
  wire txReadyNow = (|eofFlags) || (|sofFlags) || (|txCtrl_r);
  wire wrLow = wrEn && wrStrb[0];
  wire [`IRQ_WIDTH-1:0] statusClr = (wrLow && wrAddr == `REG_STATUS_OFS) ? wrData[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}};

  ////////////////////////////////////////////////////////////////
  // synchronous reset release
  sync_stage #(.WIDTH(1)) u_rst_sync (.clk(clk), .nrst(nrst), .d(1'b1), .q(rstN));

  sync_stage #(.WIDTH(13)) u_pin_sync (.clk(clk), .nrst(rstN), .q(pinSync),
    .d({~portSelectN, readNotWrite, hostRegSelectHi, hostRegSelectLo, dmaModeN, hostByteIn}));

  axil_slave u_bus (
    .clk(clk), .nrst(rstN), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .wrStrb(wrStrb), .rdAddr(rdAddr), .rdData(regRd), .rdErr(regRdErr),
    .wrErr(!(wrAddr == `REG_CTRL_OFS || wrAddr == `REG_STATUS_OFS || wrAddr == `REG_MASK_OFS ||
             wrAddr == `REG_POINTER_OFS || wrAddr == `REG_TXCTRL_OFS))
  );

  ////////////////////////////////////////////////////////////////
  // host access sequencer
  always @* begin
    state_nxt = state_r;
    isRead_nxt = isRead_r;
    reg_nxt = reg_r;
    wrByte_nxt = wrByte_r;
    pointer_nxt = pointer_r;
    byteOut_nxt = hostByteOut;
    byteOeN_nxt = hostByteOeN;
    readyN_nxt = hostReadyNOut;
    readyOeN_nxt = hostReadyOeN;
    intReq_nxt = intReq;
    doneWrite = 1'b0;
    doneRead = 1'b0;
    dmaSel = autoInc_r ? `HREG_DATA_INCR : `HREG_DATA_PLAIN;
    case (state_r)
      ST_IDLE: begin
        byteOeN_nxt = 1'b1;
        readyOeN_nxt = 1'b1;
        if (!selNS) begin
          isRead_nxt = rnwS;
          wrByte_nxt = byteS;
          // select pins only outside dma mode
          reg_nxt = dmaNS ? {selHiS, selLoS} : dmaSel;
          if (rnwS) begin
            state_nxt = ST_ACCESS;
            intReq_nxt = !(dmaNS && ({selHiS, selLoS} == `HREG_ADDR_LO || {selHiS, selLoS} == `HREG_ADDR_HI));
          end else begin
            state_nxt = ST_WRWAIT;
          end
        end
      end
      ST_WRWAIT: begin
        // write completes after select is raised
        if (selNS) begin
          state_nxt = ST_ACCESS;
          intReq_nxt = !isLocal;
        end
      end
      ST_ACCESS: begin
        if (isLocal || intAck) begin
          intReq_nxt = 1'b0;
          // pointer advances on the incrementing register
          if (reg_r == `HREG_DATA_INCR) begin
            pointer_nxt = pointerInc;
          end
          if (isRead_r) begin
            doneRead = 1'b1;
            // bit seven is msb both ways
            if (reg_r == `HREG_ADDR_LO) begin
              byteOut_nxt = pointerWide[7:0];
            end else if (reg_r == `HREG_ADDR_HI) begin
              byteOut_nxt = pointerWide[15:8];
            end else begin
              byteOut_nxt = intRdata;
            end
            byteOeN_nxt = 1'b0;
            readyN_nxt = 1'b0;
            readyOeN_nxt = 1'b0;
            state_nxt = ST_RDHOLD;
          end else begin
            doneWrite = 1'b1;
            if (reg_r == `HREG_ADDR_LO) begin
              pointer_nxt = {pointer_r[ADDR_W-1:8], wrByte_r};
            end else if (reg_r == `HREG_ADDR_HI) begin
              pointer_nxt = {wrByte_r[ADDR_W-9:0], pointer_r[7:0]};
            end
            readyN_nxt = 1'b0;
            readyOeN_nxt = 1'b0;
            state_nxt = ST_RDYLO;
          end
        end
      end
      ST_RDHOLD: begin
        if (selNS) begin
          byteOeN_nxt = 1'b1;
          readyN_nxt = 1'b1;
          state_nxt = ST_RDYHI;
        end
      end
      ST_RDYLO: begin
        readyN_nxt = 1'b1;
        state_nxt = ST_RDYHI;
      end
      ST_RDYHI: begin
        readyOeN_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
        byteOeN_nxt = 1'b1;
        readyOeN_nxt = 1'b1;
        intReq_nxt = 1'b0;
      end
    endcase
    if (wrEn && wrAddr == `REG_POINTER_OFS && state_r == ST_IDLE) begin
      pointer_nxt = wrData[ADDR_W-1:0];
    end
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_IDLE;
      isRead_r <= 1'b0;
      reg_r <= `HREG_ADDR_LO;
      wrByte_r <= 8'h00;
      pointer_r <= `POINTER_RESET;
      hostByteOut <= 8'h00;
      hostByteOeN <= 1'b1;
      hostReadyNOut <= 1'b1;
      hostReadyOeN <= 1'b1;
      intReq <= 1'b0;
      intWe <= 1'b0;
      intSel <= `HREG_ADDR_LO;
      intAddr <= {ADDR_W{1'b0}};
      intWdata <= 8'h00;
    end else begin
      state_r <= state_nxt;
      isRead_r <= isRead_nxt;
      reg_r <= reg_nxt;
      wrByte_r <= wrByte_nxt;
      pointer_r <= pointer_nxt;
      hostByteOut <= byteOut_nxt;
      hostByteOeN <= byteOeN_nxt;
      hostReadyNOut <= readyN_nxt;
      hostReadyOeN <= readyOeN_nxt;
      intReq <= intReq_nxt;
      intWe <= !isRead_nxt;
      intSel <= reg_nxt;
      intAddr <= pointer_nxt;
      intWdata <= wrByte_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers and interrupt
  always @* begin
    irqSet = {`IRQ_WIDTH{1'b0}};
    irqSet[`IRQ_HOST_WRITE_BIT] = doneWrite;
    irqSet[`IRQ_HOST_READ_BIT] = doneRead;
    irqSet[`IRQ_TX_READY_BIT] = txReadyNow && !txReadyLast_r;
    irqSet[`IRQ_RX_READY_BIT] = rxBufEmpty && !rxReadyLast_r;
    regRdErr = 1'b0;
    case (rdAddr)
      `REG_CTRL_OFS: regRd = {31'h0000_0000, autoInc_r};
      `REG_STATUS_OFS: regRd = {28'h000_0000, status_r};
      `REG_MASK_OFS: regRd = {28'h000_0000, mask_r};
      `REG_POINTER_OFS: regRd = {16'h0000, pointerWide};
      `REG_TXCTRL_OFS: regRd = {24'h00_0000, txCtrl_r};
      default: begin
        regRd = 32'h0000_0000;
        regRdErr = 1'b1;
      end
    endcase
  end

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      autoInc_r <= 1'b0;
      txCtrl_r <= `TXCTRL_RESET;
      status_r <= `STATUS_RESET;
      mask_r <= `MASK_RESET;
      txReadyLast_r <= 1'b0;
      rxReadyLast_r <= 1'b0;
      hostIrq <= 1'b0;
      mgmtRxReady <= 1'b0;
      mgmtTxReady <= 1'b0;
    end else begin
      if (wrLow && wrAddr == `REG_CTRL_OFS) begin
        autoInc_r <= wrData[`CTRL_AUTO_INC_BIT];
      end
      if (wrLow && wrAddr == `REG_MASK_OFS) begin
        mask_r <= wrData[`IRQ_WIDTH-1:0];
      end
      if (wrLow && wrAddr == `REG_TXCTRL_OFS) begin
        txCtrl_r <= wrData[7:0];
      end
      // cause kept; a new event beats a clear
      status_r <= (status_r & ~statusClr) | irqSet;
      txReadyLast_r <= txReadyNow;
      rxReadyLast_r <= rxBufEmpty;
      hostIrq <= |(status_r & mask_r);
      mgmtRxReady <= rxBufEmpty;
      mgmtTxReady <= txReadyNow;
    end
  end

endmodule

`default_nettype wire

// *** test/host_port_sva.sv ***
// checker for the host byte port boundary
`default_nettype none
module host_port_sva #(
  parameter int ADDR_W = 16,
  parameter int FLAGS = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic portSelectN,
  input wire logic rxBufEmpty,
  input wire logic [FLAGS-1:0] eofFlags,
  input wire logic [FLAGS-1:0] sofFlags,
  input wire logic mgmtRxReady,
  input wire logic mgmtTxReady,
  input wire logic hostByteOeN,
  input wire logic hostReadyNOut,
  input wire logic hostReadyOeN,
  input wire logic intReq,
  input wire logic intAck,
  input wire logic [ADDR_W-1:0] intAddr,
  input wire logic [1:0] intSel,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] upCnt;
  logic [3:0] selHighCnt;
  logic live;
  // release is resynchronised, so wait out the first edges
  assign live = upCnt == 3'h4;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upCnt <= 3'h0;
      selHighCnt <= 4'h0;
    end else begin
      if (!live) upCnt <= upCnt + 3'h1;
      if (!portSelectN) selHighCnt <= 4'h0;
      else if (selHighCnt != 4'hF) selHighCnt <= selHighCnt + 4'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rx_follow: assert property (live |=> mgmtRxReady == $past(rxBufEmpty))
    else $error("receive ready not following buffer state");
  a_tx_any_flag: assert property (live && (|eofFlags || |sofFlags) |=> mgmtTxReady)
    else $error("transmit ready low with a flag set");
  a_ready_one_high: assert property (!hostReadyOeN && hostReadyNOut |=> hostReadyOeN)
    else $error("ready driven high longer than one cycle");
  a_ready_low_first: assert property ($rose(hostReadyOeN) |-> $past(hostReadyNOut) && !$past(hostReadyNOut, 2))
    else $error("ready released without low then high");
  a_bus_with_ready: assert property ($fell(hostByteOeN) |-> !hostReadyNOut && !hostReadyOeN)
    else $error("byte bus driven without ready low");
  a_idle_float: assert property (selHighCnt == 4'hE |-> hostByteOeN && hostReadyOeN)
    else $error("pins still driven while idle");
  a_access_selected: assert property ($fell(hostReadyOeN) |-> selHighCnt < 4'hE)
    else $error("ready driven with no select");
  a_req_steady: assert property (intReq && !intAck |=> intReq && $stable(intAddr) && $stable(intSel))
    else $error("internal request changed before ack");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[2:3] bvalid)
    else $error("write response late");
  a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read response late");
  c_read_drive: cover property ($fell(hostByteOeN));
  c_int_req: cover property ($rose(intReq));
  c_write_done: cover property (bvalid ##1 !bvalid);
endmodule
bind host_byte_port host_port_sva #(.ADDR_W(ADDR_W), .FLAGS(FLAGS)) sva (.clk, .nrst, .portSelectN,
  .rxBufEmpty, .eofFlags, .sofFlags, .mgmtRxReady, .mgmtTxReady, .hostByteOeN, .hostReadyNOut,
  .hostReadyOeN, .intReq, .intAck, .intAddr, .intSel, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .arvalid, .arready, .rvalid);
`default_nettype wire

// *** test/host_cpu_model.sv ***
// host processor model on the byte port pins
`default_nettype none
module host_cpu_model (
  input wire logic clk,
  input wire logic [7:0] hostByteOut,
  input wire logic hostByteOeN,
  input wire logic hostReadyNOut,
  input wire logic hostReadyOeN,
  output logic portSelectN,
  output logic readNotWrite,
  output logic hostRegSelectHi,
  output logic hostRegSelectLo,
  output logic [7:0] hostByteIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;
  logic hostDrv;
  logic readyW;
  // pulled-up lines read high when released
  assign readyW = hostReadyOeN ? 1'b1 : hostReadyNOut;
  assign hostByteIn = hostDrv ? drv : (hostByteOeN ? 8'hFF : hostByteOut);
  initial begin
    portSelectN = 1'b1;
    readNotWrite = 1'b1;
    {hostRegSelectHi, hostRegSelectLo} = 2'h0;
    drv = 8'h00;
    hostDrv = 1'b0;
  end
  task automatic access(input logic rd, input logic [1:0] code, input logic [7:0] wd,
                        output logic [7:0] rdv, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    portSelectN <= 1'b0;
    readNotWrite <= rd;
    {hostRegSelectHi, hostRegSelectLo} <= code;
    drv <= wd;
    hostDrv <= !rd;
    if (!rd) begin
      repeat (4) @(posedge clk);
      portSelectN <= 1'b1;
    end
    do begin
      @(posedge clk);
      n++;
    end while (readyW !== 1'b0 && n < 100);
    rdv = hostByteIn;
    portSelectN <= 1'b1;
    hostDrv <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (hostReadyOeN !== 1'b1 && n < 100);
    ok = n < 100;
  endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the host byte port
`include "host_port_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, portSelectN, readNotWrite, hostRegSelectHi, hostRegSelectLo, dmaModeN;
  logic hostByteOeN, hostReadyNOut, hostReadyOeN, hostIrq, mgmtRxReady, mgmtTxReady;
  logic rxBufEmpty, intReq, intWe, intAck, lastWe, ok;
  logic [7:0] hostByteIn, hostByteOut, eofFlags, sofFlags, intWdata, intRdata, lastWd, hv;
  logic [1:0] intSel, lastSel, bresp, rresp, r;
  logic [15:0] intAddr, lastAddr;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int badCount, checkCount, i;
  initial clk = 1'b0;
  always #20 clk = ~clk;
  host_byte_port dut (.clk, .nrst, .portSelectN, .readNotWrite, .hostRegSelectHi, .hostRegSelectLo,
    .dmaModeN, .hostByteIn, .hostByteOut, .hostByteOeN, .hostReadyNOut, .hostReadyOeN, .hostIrq,
    .mgmtRxReady, .mgmtTxReady, .rxBufEmpty, .eofFlags, .sofFlags, .intReq, .intWe, .intSel, .intAddr,
    .intWdata, .intRdata, .intAck, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  host_cpu_model host (.clk, .hostByteOut, .hostByteOeN, .hostReadyNOut, .hostReadyOeN, .portSelectN,
    .readNotWrite, .hostRegSelectHi, .hostRegSelectLo, .hostByteIn);
  // internal store answers one cycle late, data tied to address
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intAck <= 1'b0;
      intRdata <= 8'h00;
    end else begin
      intAck <= intReq && !intAck;
      intRdata <= intAddr[7:0] ^ 8'h5A;
      if (intReq) begin
        {lastWe, lastSel, lastAddr, lastWd} <= {intWe, intSel, intAddr, intWdata};
      end
    end
  end
  ////////////////////////////////////////
  task results();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      badCount++;
      results();
    end
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
    if (n >= 100) begin
      badCount++;
      results();
    end
  endtask
  task automatic hx(input logic rd, input logic [1:0] c, input logic [7:0] w);
    host.access(rd, c, w, hv, ok);
    if (!ok) begin
      badCount++;
      results();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    {nrst, dmaModeN, rxBufEmpty, eofFlags, sofFlags} = 19'h20000;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 5; i++) begin
      axr(8'(i * 4));
      chk("reset value", d, 32'h0);
    end
    axr(8'h20);
    chk("unmapped read", 32'(r), 32'(`RESP_SLVERR));
    axw(8'h20, 32'h1);
    chk("unmapped write", 32'(r), 32'(`RESP_SLVERR));
    hx(1'b0, `HREG_ADDR_LO, 8'h34);
    hx(1'b0, `HREG_ADDR_HI, 8'h12);
    axr(`REG_POINTER_OFS);
    chk("pointer", d, 32'h1234);
    hx(1'b1, `HREG_ADDR_HI, 8'h00);
    chk("byte read", 32'(hv), 32'h12);
    axr(`REG_STATUS_OFS);
    chk("cause", d, 32'h3);
    chk("irq masked", 32'(hostIrq), 32'h0);
    axw(`REG_MASK_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq on", 32'(hostIrq), 32'h1);
    axw(`REG_STATUS_OFS, 32'h1);
    repeat (3) @(posedge clk);
    chk("irq off", 32'(hostIrq), 32'h0);
    dmaModeN <= 1'b0;
    hx(1'b1, `HREG_ADDR_LO, 8'h00);
    chk("dma plain", 32'(lastSel), 32'(`HREG_DATA_PLAIN));
    chk("dma addr", 32'(lastAddr), 32'h1234);
    chk("dma data", 32'(hv), 32'h6E);
    axr(`REG_POINTER_OFS);
    chk("kept", d, 32'h1234);
    axw(`REG_CTRL_OFS, 32'h1);
    hx(1'b0, `HREG_ADDR_LO, 8'hA5);
    chk("inc write", {5'h00, lastWe, lastSel, lastAddr, lastWd}, {5'h00, 1'b1, `HREG_DATA_INCR, 16'h1234, 8'hA5});
    axr(`REG_POINTER_OFS);
    chk("bumped", d, 32'h1235);
    hx(1'b1, `HREG_ADDR_HI, 8'h00);
    chk("inc read", {7'h00, lastWe, lastAddr, hv}, {7'h00, 1'b0, 16'h1235, 8'h6F});
    axr(`REG_POINTER_OFS);
    chk("bumped", d, 32'h1236);
    dmaModeN <= 1'b1;
    hx(1'b1, `HREG_DATA_INCR, 8'h00);
    chk("direct data", {22'h000000, lastSel, hv}, {22'h000000, `HREG_DATA_INCR, 8'h6C});
    rxBufEmpty <= 1'b1;
    repeat (3) @(posedge clk);
    chk("rx ready", 32'(mgmtRxReady), 32'h1);
    rxBufEmpty <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rx ready", 32'(mgmtRxReady), 32'h0);
    for (i = 0; i < 17; i++) begin
      {sofFlags, eofFlags} <= 16'(17'h1 << i);
      repeat (3) @(posedge clk);
      chk("tx ready", 32'(mgmtTxReady), 32'(i < 16));
    end
    axw(`REG_TXCTRL_OFS, 32'h80);
    repeat (3) @(posedge clk);
    chk("tx control", 32'(mgmtTxReady), 32'h1);
    axw(`REG_TXCTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk("tx control", 32'(mgmtTxReady), 32'h0);
    axr(`REG_STATUS_OFS);
    chk("rise causes", d & 32'hC, 32'hC);
    results();
  end
endmodule
`default_nettype wire
